// file: bench/cwrc_core_asserts.sv
// Port-level assertions for the working register file.
// Assumes binding into every cwrc_core instance.
`timescale 1ns/10ps
`default_nettype none

module cwrc_core_asserts #(
	parameter int NUM_ALT = 4
) (
	input wire logic                 clk,
	input wire logic                 reset,
	input wire logic                 clk_en,
	input wire logic                 wr_en,
	input wire cwrc_pkg::cwrc_idx_t  wr_addr,
	input wire cwrc_pkg::cwrc_word_t wr_data,
	input wire logic                 int_enter,
	input wire logic                 int_return,
	input wire logic                 bank_swap_instr,
	input wire cwrc_pkg::cwrc_bank_t swap_bank,
	input wire logic                 pc_load,
	input wire cwrc_pkg::cwrc_pc_t   pc_load_value,
	input wire logic                 pc_step,
	input wire cwrc_pkg::cwrc_word_t stack_pointer_reg,
	input wire cwrc_pkg::cwrc_stat_t bank_status_reg,
	input wire cwrc_pkg::cwrc_pc_t   pc_reg
);
	import cwrc_pkg::*;
	// Swap counts only without a same-cycle entry or return; a mapped entry when idle or a return in a handler wins
	wire logic sw = clk_en && bank_swap_instr && !int_enter && !int_return;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ****************************************
	// Properties
	// ****************************************
	// manual select shown
	property p_swap; sw && swap_bank <= 3'h4 |=>
		bank_status_reg[2:0] == $past(swap_bank); endproperty
	a_swap: assert property (p_swap) else $error("swap lost");
	property p_swbad; sw && swap_bank > 3'h4 && !int_return |=>
		$stable(bank_status_reg); endproperty
	a_swbad: assert property (p_swbad) else $error("bad swap");
	property p_stat; bank_status_reg[15:11] == 5'h0 &&
		bank_status_reg[7:3] == 5'h0 && bank_status_reg[10:8] <= NUM_ALT &&
		bank_status_reg[2:0] <= NUM_ALT; endproperty
	a_stat: assert property (p_stat) else $error("status form");
	property p_man; clk_en && !bank_swap_instr |=>
		$stable(bank_status_reg[2:0]); endproperty
	a_man: assert property (p_man) else $error("manual moved");
	property p_pcld; clk_en && pc_load |=>
		pc_reg == $past(pc_load_value); endproperty
	a_pcld: assert property (p_pcld) else $error("pc load");
	property p_pcst; clk_en && pc_step && !pc_load |=>
		pc_reg == cwrc_pc_t'($past(pc_reg) + 23'h1); endproperty
	a_pcst: assert property (p_pcst) else $error("pc step");
	property p_sp; clk_en && wr_en && wr_addr == 4'hf |=>
		stack_pointer_reg == $past(wr_data); endproperty
	a_sp: assert property (p_sp) else $error("sp write");
	property p_frz; !clk_en |=> $stable(pc_reg) &&
		$stable(bank_status_reg) && $stable(stack_pointer_reg); endproperty
	a_frz: assert property (p_frz) else $error("not frozen");
	c_swap: cover property (sw);
	c_irq: cover property (clk_en && int_enter);
	c_pc: cover property (clk_en && pc_load);
endmodule : cwrc_core_asserts

bind cwrc_core cwrc_core_asserts #(.NUM_ALT(NUM_ALT)) u_chk (
	.clk              (clk),
	.reset            (reset),
	.clk_en           (clk_en),
	.wr_en            (wr_en),
	.wr_addr          (wr_addr),
	.wr_data          (wr_data),
	.int_enter        (int_enter),
	.int_return       (int_return),
	.bank_swap_instr  (bank_swap_instr),
	.swap_bank        (swap_bank),
	.pc_load          (pc_load),
	.pc_load_value    (pc_load_value),
	.pc_step          (pc_step),
	.stack_pointer_reg(stack_pointer_reg),
	.bank_status_reg  (bank_status_reg),
	.pc_reg           (pc_reg)
);

`default_nettype wire

// file: bench/cwrc_core_tb.sv
// Self-checking bench for the working register file.
// Assumes the checker is bound in from its own file.
`timescale 1ns/10ps
`default_nettype none

module cwrc_core_tb;
	import cwrc_pkg::*;
	logic        clk, reset, clk_en, wr_en, int_enter, int_return;
	logic        bank_swap_instr, pc_load, pc_step;
	logic [11:0] alt_bank_config_word;
	cwrc_idx_t   wr_addr, rd_addr_a, rd_addr_b;
	cwrc_word_t  wr_data, rd_data_a, rd_data_b, stack_pointer_reg;
	cwrc_stat_t  bank_status_reg;
	cwrc_ipl_t   interrupt_priority_level;
	cwrc_bank_t  swap_bank;
	cwrc_pc_t    pc_load_value, pc_reg;
	int          n_fail = 0;
	int          n_checks = 0;
	// Bank tied to each level under config 7e9; zero is none
	cwrc_bank_t  lvl_bank [8] = '{3'h0,3'h1,3'h0,3'h4,3'h0,3'h2,3'h0,3'h3};

	cwrc_core dut (
		.clk                     (clk),
		.reset                   (reset),
		.clk_en                  (clk_en),
		.alt_bank_config_word    (alt_bank_config_word),
		.wr_en                   (wr_en),
		.wr_addr                 (wr_addr),
		.wr_data                 (wr_data),
		.rd_addr_a               (rd_addr_a),
		.rd_addr_b               (rd_addr_b),
		.int_enter               (int_enter),
		.interrupt_priority_level(interrupt_priority_level),
		.int_return              (int_return),
		.bank_swap_instr         (bank_swap_instr),
		.swap_bank               (swap_bank),
		.pc_load                 (pc_load),
		.pc_load_value           (pc_load_value),
		.pc_step                 (pc_step),
		.rd_data_a               (rd_data_a),
		.rd_data_b               (rd_data_b),
		.stack_pointer_reg       (stack_pointer_reg),
		.bank_status_reg         (bank_status_reg),
		.pc_reg                  (pc_reg)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk_w(string s, cwrc_word_t e, cwrc_word_t g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk_w
	task automatic chk_pc(string s, cwrc_pc_t e, cwrc_pc_t g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk_pc
	task automatic complete_run;
		if (n_fail == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	task automatic wr(cwrc_idx_t a, cwrc_word_t d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	// Address held three edges, past the two-edge read latency
	task automatic rd(cwrc_idx_t a, cwrc_word_t e);
		@(posedge clk);
		rd_addr_a <= a;
		rd_addr_b <= a;
		repeat (3) @(posedge clk);
		#1;
		chk_w("rd_data_a", e, rd_data_a);
		chk_w("rd_data_b", e, rd_data_b);
	endtask : rd
	// One-cycle entry, return or swap strobe
	task automatic go(logic i, logic r, logic b, cwrc_bank_t v);
		@(posedge clk);
		int_enter <= i;
		int_return <= r;
		bank_swap_instr <= b;
		swap_bank <= v;
		interrupt_priority_level <= v;
		@(posedge clk);
		{int_enter, int_return, bank_swap_instr} <= 3'h0;
		#1;
	endtask : go
	task automatic pcgo(logic e, logic ld, logic st, cwrc_pc_t v);
		@(posedge clk);
		clk_en <= e;
		pc_load <= ld;
		pc_step <= st;
		pc_load_value <= v;
		@(posedge clk);
		{clk_en, pc_load, pc_step} <= 3'h4;
		#1;
	endtask : pcgo

	// ****************************************
	// Scenarios
	// ****************************************
	// reset state
	task automatic t_reset;
		chk_w("status", 16'h0, bank_status_reg);
		chk_w("sp", 16'h0, stack_pointer_reg);
		chk_pc("pc", 23'h0, pc_reg);
	endtask : t_reset
	task automatic t_regs;
		cwrc_word_t d;
		for (int i = 0; i < 16; i++) begin
			d = cwrc_word_t'(16'h1111 * i + 16'h0101);
			wr(cwrc_idx_t'(i), d);
			rd(cwrc_idx_t'(i), d);
		end
		chk_w("sp", d, stack_pointer_reg);
	endtask : t_regs
	task automatic t_banks;
		cwrc_bank_t k;
		for (int b = 0; b < 5; b++) begin
			k = cwrc_bank_t'(b);
			go(1'b0, 1'b0, 1'b1, k);
			chk_w("status", {5'h0, k, 5'h0, k}, bank_status_reg);
			wr(4'h3, {13'h1600, k});
		end
		wr(4'hf, 16'h5a5a);
		go(1'b0, 1'b0, 1'b1, 3'h5);
		chk_w("status", 16'h0404, bank_status_reg);
		for (int b = 0; b < 5; b++) begin
			k = cwrc_bank_t'(b);
			go(1'b0, 1'b0, 1'b1, k);
			rd(4'h3, {13'h1600, k});
			rd(4'hf, 16'h5a5a);
		end
	endtask : t_banks
	task automatic t_irq;
		cwrc_bank_t k;
		go(1'b0, 1'b0, 1'b1, 3'h0);
		for (int l = 1; l < 8; l++) begin
			k = lvl_bank[l];
			go(1'b1, 1'b0, 1'b0, cwrc_bank_t'(l));
			chk_w("status", {5'h0, k, 8'h0}, bank_status_reg);
			rd(4'h3, {13'h1600, k});
			go(1'b0, 1'b1, 1'b0, 3'h0);
			chk_w("status", 16'h0, bank_status_reg);
		end
		// Swap inside a handler, nested entry ignored, return restores
		go(1'b1, 1'b0, 1'b0, 3'h1);
		go(1'b0, 1'b0, 1'b1, 3'h2);
		chk_w("status", 16'h0202, bank_status_reg);
		go(1'b1, 1'b0, 1'b0, 3'h3);
		chk_w("status", 16'h0202, bank_status_reg);
		go(1'b0, 1'b1, 1'b0, 3'h0);
		chk_w("status", 16'h0002, bank_status_reg);
	endtask : t_irq
	task automatic t_pc;
		pcgo(1'b1, 1'b1, 1'b1, 23'h7ffffe);
		chk_pc("pc", 23'h7ffffe, pc_reg);
		pcgo(1'b1, 1'b0, 1'b1, 23'h0);
		chk_pc("pc", 23'h7fffff, pc_reg);
		pcgo(1'b1, 1'b0, 1'b1, 23'h0);
		chk_pc("pc", 23'h0, pc_reg);
		// Load while disabled must not land
		pcgo(1'b0, 1'b1, 1'b1, 23'h123456);
		chk_pc("pc", 23'h0, pc_reg);
	endtask : t_pc

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		reset = 1'b1;
		clk_en = 1'b1;
		alt_bank_config_word = 12'h7e9;
		{wr_en, int_enter, int_return, bank_swap_instr} = 4'h0;
		{pc_load, pc_step} = 2'h0;
		{wr_addr, rd_addr_a, rd_addr_b, wr_data} = 28'h0;
		{interrupt_priority_level, swap_bank, pc_load_value} = 29'h0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_regs();
		t_banks();
		t_irq();
		t_pc();
		complete_run();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		complete_run();
	end
endmodule : cwrc_core_tb

`default_nettype wire

// file: rtl/cwrc_bank_mem.sv
// One bank of banked working registers, indices 0 to 14.
// Assumes one write port and two registered read ports on the same clock.
`timescale 1ns/10ps
`default_nettype none

module cwrc_bank_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 15
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire logic             wr_en,
	input  wire logic [3:0]       wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [3:0]       rd_addr_a,
	input  wire logic [3:0]       rd_addr_b,
	output var  logic [WIDTH-1:0] rd_data_a,
	output var  logic [WIDTH-1:0] rd_data_b
);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [WIDTH-1:0] rd_a_next;
	logic [WIDTH-1:0] rd_b_next;

	// Next contents; unwritten words keep value
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_next[i] = mem_reg[i];
			if (wr_en && (wr_addr == 4'(i))) begin
				mem_next[i] = wr_data;
			end
		end
		rd_a_next = (int'(rd_addr_a) < DEPTH) ? mem_reg[rd_addr_a] : '0;
		rd_b_next = (int'(rd_addr_b) < DEPTH) ? mem_reg[rd_addr_b] : '0;
	end

	// Storage and registered read data
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			rd_data_a <= '0;
			rd_data_b <= '0;
		end else if (clk_en) begin
			mem_reg   <= mem_next;
			rd_data_a <= rd_a_next;
			rd_data_b <= rd_b_next;
		end
	end

endmodule : cwrc_bank_mem

`default_nettype wire

// file: rtl/cwrc_core.sv
// Working register file: sixteen registers, four alternate banks,
// interrupt-linked and manual bank selection, and the program counter.
// Assumes a sequencer on the same clock issues reads, writes, interrupt
// entry/return and swap strobes; configuration word is static after reset.
`timescale 1ns/10ps
`default_nettype none
`include "cwrc_map.svh"

module cwrc_core
	import cwrc_pkg::*;
#(
	parameter int NUM_ALT = `CWRC_NUM_ALT
) (
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 clk_en,
	input  wire logic [11:0]          alt_bank_config_word,
	input  wire logic                 wr_en,
	input  wire cwrc_pkg::cwrc_idx_t  wr_addr,
	input  wire cwrc_pkg::cwrc_word_t wr_data,
	input  wire cwrc_pkg::cwrc_idx_t  rd_addr_a,
	input  wire cwrc_pkg::cwrc_idx_t  rd_addr_b,
	input  wire logic                 int_enter,
	input  wire cwrc_pkg::cwrc_ipl_t  interrupt_priority_level,
	input  wire logic                 int_return,
	input  wire logic                 bank_swap_instr,
	input  wire cwrc_pkg::cwrc_bank_t swap_bank,
	input  wire logic                 pc_load,
	input  wire cwrc_pkg::cwrc_pc_t   pc_load_value,
	input  wire logic                 pc_step,
	output var  cwrc_pkg::cwrc_word_t rd_data_a,
	output var  cwrc_pkg::cwrc_word_t rd_data_b,
	output var  cwrc_pkg::cwrc_word_t stack_pointer_reg,
	output var  cwrc_pkg::cwrc_stat_t bank_status_reg,
	output var  cwrc_pkg::cwrc_pc_t   pc_reg
);

	localparam int NBANK = NUM_ALT + 1;
	localparam int DEPTH = `CWRC_NUM_REGS - 1;

	// ****************************************
	// Bank selection state
	// ****************************************
	cwrc_bank_t  active_bank_index_reg, active_bank_index_next;
	cwrc_bank_t  manual_bank_index_reg, manual_bank_index_next;
	cwrc_bank_t  saved_bank_reg, saved_bank_next;
	cwrc_state_t state_reg, state_next;
	cwrc_bank_t  irq_bank;
	logic        irq_hit;

	// Config field lookup: bank n uses bits [3n-1:3n-3]
	always_comb begin
		irq_bank = `CWRC_DEFAULT_BANK;
		irq_hit  = 1'b0;
		for (int n = 1; n <= NUM_ALT; n++) begin
			if (!irq_hit && interrupt_priority_level != 3'h0 &&
			    alt_bank_config_word[3*n-1 -: 3] ==
			    interrupt_priority_level) begin
				irq_bank = 3'(n);
				irq_hit  = 1'b1;
			end
		end
	end

	// Bank controller; one nesting level of saved context
	always_comb begin
		active_bank_index_next = active_bank_index_reg;
		manual_bank_index_next = manual_bank_index_reg;
		saved_bank_next        = saved_bank_reg;
		state_next             = state_reg;
		case (state_reg)
			CWRC_IDLE: begin
				if (int_enter && irq_hit) begin
					saved_bank_next        = active_bank_index_reg;
					active_bank_index_next = irq_bank;
					state_next             = CWRC_IN_ISR;
				end else if (bank_swap_instr &&
				             int'(swap_bank) < NBANK) begin
					active_bank_index_next = swap_bank;
					manual_bank_index_next = swap_bank;
				end
			end
			CWRC_IN_ISR: begin
				if (int_return) begin
					active_bank_index_next = saved_bank_reg;
					state_next             = CWRC_IDLE;
				end else if (bank_swap_instr &&
				             int'(swap_bank) < NBANK) begin
					active_bank_index_next = swap_bank;
					manual_bank_index_next = swap_bank;
				end
			end
			default: begin
				state_next = CWRC_IDLE;
			end
		endcase
	end

	// Bank state registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			active_bank_index_reg <= `CWRC_DEFAULT_BANK;
			manual_bank_index_reg <= `CWRC_DEFAULT_BANK;
			saved_bank_reg        <= `CWRC_DEFAULT_BANK;
			state_reg             <= CWRC_IDLE;
		end else if (clk_en) begin
			active_bank_index_reg <= active_bank_index_next;
			manual_bank_index_reg <= manual_bank_index_next;
			saved_bank_reg        <= saved_bank_next;
			state_reg             <= state_next;
		end
	end

	// ****************************************
	// Banked storage
	// ****************************************
	cwrc_word_t bank_rd_a [NBANK];
	cwrc_word_t bank_rd_b [NBANK];

	// one store per bank, 15 words
	// only the active bank is written
	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		cwrc_bank_mem #(
			.WIDTH(`CWRC_REG_WIDTH),
			.DEPTH(DEPTH)
		) u_mem (
			.clk      (clk),
			.reset    (reset),
			.clk_en   (clk_en),
			.wr_en    (wr_en && wr_addr != `CWRC_SP_INDEX &&
			           active_bank_index_reg == 3'(b)),
			.wr_addr  (wr_addr),
			.wr_data  (wr_data),
			.rd_addr_a(rd_addr_a),
			.rd_addr_b(rd_addr_b),
			.rd_data_a(bank_rd_a[b]),
			.rd_data_b(bank_rd_b[b])
		);
	end

	// ****************************************
	// Stack pointer and read steering
	// ****************************************
	cwrc_word_t sp_next;
	logic       sel_sp_a_reg, sel_sp_b_reg;
	cwrc_bank_t rd_bank_reg;
	cwrc_word_t rd_a_next, rd_b_next;

	always_comb begin
		sp_next = stack_pointer_reg;
		if (wr_en && wr_addr == `CWRC_SP_INDEX) begin
			sp_next = wr_data;
		end
	end

	// Read data is one cycle late, so steering is delayed to match
	// both ports see every register
	always_comb begin
		rd_a_next = sel_sp_a_reg ? stack_pointer_reg : bank_rd_a[rd_bank_reg];
		rd_b_next = sel_sp_b_reg ? stack_pointer_reg : bank_rd_b[rd_bank_reg];
	end

	// Steering registers and stack pointer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stack_pointer_reg <= `CWRC_SP_RESET;
			sel_sp_a_reg      <= 1'b0;
			sel_sp_b_reg      <= 1'b0;
			rd_bank_reg       <= `CWRC_DEFAULT_BANK;
		end else if (clk_en) begin
			stack_pointer_reg <= sp_next;
			sel_sp_a_reg      <= (rd_addr_a == `CWRC_SP_INDEX);
			sel_sp_b_reg      <= (rd_addr_b == `CWRC_SP_INDEX);
			rd_bank_reg       <= active_bank_index_reg;
		end
	end

	// Output register stage; adds a second cycle of read latency
	// 16-bit results
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_data_a <= '0;
			rd_data_b <= '0;
		end else if (clk_en) begin
			rd_data_a <= rd_a_next;
			rd_data_b <= rd_b_next;
		end
	end

	// ****************************************
	// Status and program counter
	// ****************************************
	cwrc_stat_t stat_next;
	cwrc_pc_t   pc_next;

	always_comb begin
		stat_next = '0;
		stat_next[`CWRC_STAT_ACT_LSB +: 3] = active_bank_index_next;
		stat_next[`CWRC_STAT_MAN_LSB +: 3] = manual_bank_index_next;
	end

	always_comb begin
		pc_next = pc_reg;
		if (pc_load) begin
			pc_next = pc_load_value;
		end else if (pc_step) begin
			pc_next = pc_reg + 23'h000001;
		end
	end

	// Status and counter registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bank_status_reg <= '0;
			pc_reg          <= `CWRC_PC_RESET;
		end else if (clk_en) begin
			bank_status_reg <= stat_next;
			pc_reg          <= pc_next;
		end
	end

endmodule : cwrc_core

`default_nettype wire

// file: rtl/cwrc_map.svh
// Constants for the working register file with alternate banks.
// Assumes inclusion by the package and the design modules only.
`ifndef CWRC_MAP_SVH
`define CWRC_MAP_SVH

// ****************************************
// Geometry
// ****************************************
`define CWRC_NUM_REGS      16
`define CWRC_REG_WIDTH     16
`define CWRC_NUM_ALT       4
`define CWRC_BANK_WIDTH    3
`define CWRC_SP_INDEX      4'hf
`define CWRC_PC_WIDTH      23
`define CWRC_IPL_WIDTH     3

// ****************************************
// Reset values and field positions
// ****************************************
`define CWRC_DEFAULT_BANK  3'h0
`define CWRC_PC_RESET      23'h000000
`define CWRC_SP_RESET      16'h0000
`define CWRC_STAT_ACT_LSB  8
`define CWRC_STAT_MAN_LSB  0
`define CWRC_CFG_FIELD_W   3

`endif

// file: rtl/cwrc_pkg.sv
// Types shared by the working register file modules.
// Assumes cwrc_map.svh is on the include path.
`default_nettype none
`include "cwrc_map.svh"

package cwrc_pkg;
	typedef logic [`CWRC_REG_WIDTH-1:0]  cwrc_word_t;
	typedef logic [3:0]                  cwrc_idx_t;
	typedef logic [`CWRC_BANK_WIDTH-1:0] cwrc_bank_t;
	typedef logic [`CWRC_IPL_WIDTH-1:0]  cwrc_ipl_t;
	typedef logic [`CWRC_PC_WIDTH-1:0]   cwrc_pc_t;
	typedef logic [15:0]                 cwrc_stat_t;
	// Bank switch controller states
	typedef enum logic [1:0] {
		CWRC_IDLE,
		CWRC_IN_ISR
	} cwrc_state_t;
endpackage : cwrc_pkg

`default_nettype wire
